// [logic/ufdr_pkg.sv]
// shared constants and decoders for the uart fifo setup and dma request block
package ufdr_pkg;
    // queue geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH  = 32;
    localparam int unsigned PTR_W  = 5;
    localparam int unsigned CNT_W  = 6;
    localparam logic [5:0]  CAP_FULL = 6'h20;
    localparam logic [5:0]  CAP_ONE  = 6'h01;
    // register byte offsets
    localparam logic [31:0] OFS_SETUP   = 32'h0000_0000;
    localparam logic [31:0] OFS_IRQ_EN  = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS  = 32'h0000_0008;
    localparam logic [31:0] OFS_TX_DATA = 32'h0000_000C;
    localparam logic [31:0] OFS_RX_DATA = 32'h0000_0010;
    // fifo_setup fields
    localparam int unsigned SET_EN     = 0;
    localparam int unsigned SET_RX_FL  = 1;
    localparam int unsigned SET_TX_FL  = 2;
    localparam int unsigned SET_DMA    = 3;
    localparam int unsigned SET_TX_THR = 4;
    localparam int unsigned SET_RX_THR = 6;
    localparam logic [7:0]  SETUP_RST  = 8'h00;
    // irq enable fields
    localparam int unsigned IEN_RX    = 0;
    localparam int unsigned IEN_TX    = 1;
    localparam logic [1:0]  IEN_RST   = 2'h0;
    // status fields
    localparam int unsigned ST_TX_CNT = 0;
    localparam int unsigned ST_RX_CNT = 8;
    localparam int unsigned ST_TX_REQ = 16;
    localparam int unsigned ST_RX_REQ = 17;
    localparam int unsigned ST_RX_IRQ = 18;
    localparam int unsigned ST_TX_IRQ = 19;
    localparam int unsigned ST_EN     = 20;
    // threshold levels in bytes
    localparam logic [5:0] RX_LVL_0 = 6'h08;
    localparam logic [5:0] RX_LVL_1 = 6'h10;
    localparam logic [5:0] RX_LVL_2 = 6'h18;
    localparam logic [5:0] RX_LVL_3 = 6'h1C;
    localparam logic [5:0] TX_LVL_0 = 6'h10;
    localparam logic [5:0] TX_LVL_1 = 6'h08;
    localparam logic [5:0] TX_LVL_2 = 6'h18;
    localparam logic [5:0] TX_LVL_3 = 6'h1E;

    function automatic logic [5:0] rx_level(input logic [1:0] code);
        logic [5:0] lvl;
        unique case (code)
            2'h0: lvl = RX_LVL_0;
            2'h1: lvl = RX_LVL_1;
            2'h2: lvl = RX_LVL_2;
            2'h3: lvl = RX_LVL_3;
        endcase
        return lvl;
    endfunction

    function automatic logic [5:0] tx_level(input logic [1:0] code);
        logic [5:0] lvl;
        unique case (code)
            2'h0: lvl = TX_LVL_0;
            2'h1: lvl = TX_LVL_1;
            2'h2: lvl = TX_LVL_2;
            2'h3: lvl = TX_LVL_3;
        endcase
        return lvl;
    endfunction
endpackage

// [logic/ufdr_queue.sv]
// character queue with flush and one-deep legacy capacity
`timescale 1ns/10ps
module ufdr_queue (
    // clocking
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic       sys_rst,
    // control
    input  wire logic       flush,
    input  wire logic       oneDeep,
    // fill side
    input  wire logic       push,
    input  wire logic [7:0] pushData,
    // drain side
    input  wire logic       pop,
    output logic      [7:0] headData,
    // occupancy
    output logic      [5:0] count,
    output logic            full,
    output logic            empty
);
    logic [7:0] mem [0:ufdr_pkg::DEPTH-1];
    logic [4:0] wrPtr;
    logic [4:0] rdPtr;
    logic [4:0] next_wrPtr;
    logic [4:0] next_rdPtr;
    logic [5:0] next_count;
    logic       doPush;
    logic       doPop;

    assign full  = count >= (oneDeep ? ufdr_pkg::CAP_ONE
                                     : ufdr_pkg::CAP_FULL);
    assign empty = count == 6'h00;
    assign doPush = push && !full && !flush;
    assign doPop  = pop && !empty && !flush;
    assign headData = mem[rdPtr];

    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (flush) begin
            next_wrPtr = 5'h00;
            next_rdPtr = 5'h00;
            next_count = 6'h00;
        end else begin
            if (doPush) begin
                next_wrPtr = wrPtr + 5'h01;
            end
            if (doPop) begin
                next_rdPtr = rdPtr + 5'h01;
            end
            next_count = count + 6'(doPush) - 6'(doPop);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= 5'h00;
            rdPtr <= 5'h00;
            count <= 6'h00;
        end else if (ce) begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            if (doPush) begin
                mem[wrPtr] <= pushData;
            end
        end
    end

    a_depth_bound: assert property (
        @(posedge clk) disable iff (sys_rst)
        count <= ufdr_pkg::CAP_FULL)
        else $error("queue count beyond capacity");
endmodule

// [logic/ufdr_ahb_slave.sv]
// ahb-lite slave front end, zero wait state while ce is high, word registers
`timescale 1ns/10ps
module ufdr_ahb_slave (
    // clocking
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        sys_rst,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // register side
    output logic             rdStrobe,
    output logic      [31:0] rdAddr,
    input  wire logic [31:0] rdValue,
    output logic             wrStrobe,
    output logic      [31:0] wrAddr,
    output logic      [31:0] wrData
);
    logic        take;
    logic        wrPend;
    logic        next_wrPend;
    logic [31:0] next_wrAddr;
    logic [31:0] next_hrdata;

    // only word transfers are issued, size is not decoded
    assign take      = hsel && htrans[1] && hready && ce;
    assign rdStrobe  = take && !hwrite;
    assign rdAddr    = haddr;
    assign wrStrobe  = wrPend && ce;
    assign wrData    = hwdata;
    assign hreadyout = ce;
    assign hresp     = 1'b0;

    always_comb begin
        next_wrPend = wrPend && !ce;
        next_wrAddr = wrAddr;
        next_hrdata = hrdata;
        if (take) begin
            next_wrPend = hwrite;
            next_wrAddr = haddr;
            if (!hwrite) begin
                next_hrdata = rdValue;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            wrAddr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend <= next_wrPend;
            wrAddr <= next_wrAddr;
            hrdata <= next_hrdata;
        end
    end
endmodule

// [logic/ufdr_top.sv]
// uart fifo setup, queues and dma request outputs
//
// Summary of operation
// - single mode: transmit request low while the transmit queue is empty.
// - single mode: receive request low once a character sits in the slot.
// - block mode: transmit interrupt while occupancy below transmit threshold.
// - receive interrupt at threshold; queue keeps filling until full.
// - receive threshold codes 00..11 give 8, 16, 24, 28 bytes.
// - transmit threshold codes 00..11 give 16, 8, 24, 30; default 16.
// - transmit-empty interrupt when transmit occupancy below threshold.
// - setup bit 3 selects single (0, default) or block (1) mode.
// - single or disabled: transmit request low while empty, high after write.
// - single or disabled: receive request low while data waits.
// - block mode: transmit request high only when transmit queue full.
// - block mode: receive request low on threshold or time-out until empty.
// - setup bit 2 flushes transmit queue, then reads back as 0.
// - setup bit 1 flushes receive queue, then reads back as 0.
// - setup bit 0 enables both queues; disabled after reset.
// - other setup bits are written only when bit 0 is written as 1.
// - receive interrupt withdrawn once count falls below threshold.
// - receive interrupt output gated by receiver-ready enable bit.
`timescale 1ns/10ps
module ufdr_top (
    // clocking
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // transmit shifter side
    input  wire logic        txPop,
    output logic      [7:0]  txData,
    output logic             txEmpty,
    // receive shifter side
    input  wire logic        rxPush,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxTimeout,
    output logic             rxFull,
    // dma requests
    output logic             txDmaRequestN,
    output logic             rxDmaRequestN,
    // interrupt conditions
    output logic             rxReadyIrq,
    output logic             txEmptyIrq,
    output logic             fifoEnabled
);
    logic        rdStrobe;
    logic [31:0] rdAddr;
    logic [31:0] rdValue;
    logic        wrStrobe;
    logic [31:0] wrAddr;
    logic [31:0] wrData;

    logic [7:0]  setup;
    logic [7:0]  next_setup;
    logic [1:0]  irqEn;
    logic [1:0]  next_irqEn;
    logic        wrSetup;
    logic        txFlush;
    logic        rxFlush;
    logic        txPush;
    logic        rxPop;
    logic        hostPop;
    logic        blockMode;
    logic        oneDeep;

    logic [5:0]  txCount;
    logic [5:0]  rxCount;
    logic        txFull;
    logic        rxEmpty;
    logic [7:0]  rxHead;
    logic [5:0]  rxLevel;
    logic [5:0]  txLevel;
    logic        rxCond;
    logic        txCond;
    logic        rxSet;

    logic        next_txReqN;
    logic        next_rxReqN;
    logic        next_rxIrq;
    logic        next_txIrq;

    ufdr_ahb_slave u_bus (
        .clk       (clk),
        .ce        (ce),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rdStrobe  (rdStrobe),
        .rdAddr    (rdAddr),
        .rdValue   (rdValue),
        .wrStrobe  (wrStrobe),
        .wrAddr    (wrAddr),
        .wrData    (wrData)
    );

    ufdr_queue u_txq (
        .clk      (clk),
        .ce       (ce),
        .sys_rst  (sys_rst),
        .flush    (txFlush),
        .oneDeep  (oneDeep),
        .push     (txPush),
        .pushData (wrData[7:0]),
        .pop      (txPop),
        .headData (txData),
        .count    (txCount),
        .full     (txFull),
        .empty    (txEmpty)
    );

    ufdr_queue u_rxq (
        .clk      (clk),
        .ce       (ce),
        .sys_rst  (sys_rst),
        .flush    (rxFlush),
        .oneDeep  (oneDeep),
        .push     (rxPush),
        .pushData (rxData),
        .pop      (rxPop),
        .headData (rxHead),
        .count    (rxCount),
        .full     (rxFull),
        .empty    (rxEmpty)
    );

    // mode decode
    assign fifoEnabled = setup[ufdr_pkg::SET_EN];
    assign oneDeep     = !fifoEnabled;
    assign blockMode   = fifoEnabled && setup[ufdr_pkg::SET_DMA];
    assign rxLevel = ufdr_pkg::rx_level(setup[ufdr_pkg::SET_RX_THR +: 2]);
    assign txLevel = ufdr_pkg::tx_level(setup[ufdr_pkg::SET_TX_THR +: 2]);
    assign wrSetup = wrStrobe && wrAddr == ufdr_pkg::OFS_SETUP;
    assign txPush  = wrStrobe && wrAddr == ufdr_pkg::OFS_TX_DATA;
    assign hostPop = rdStrobe && rdAddr == ufdr_pkg::OFS_RX_DATA;
    assign rxPop   = hostPop;

    // interrupt conditions: threshold in fifo mode, otherwise one char (rx) or empty queue (tx)
    assign rxCond = fifoEnabled ? (rxCount >= rxLevel)
                                : !rxEmpty;
    assign txCond = fifoEnabled ? (txCount < txLevel)
                                : (txCount == 6'h00);
    assign rxSet  = !rxEmpty && (rxCount >= rxLevel || rxTimeout);

    // setup register and flush strobes
    always_comb begin
        next_setup = setup;
        next_irqEn = irqEn;
        txFlush    = 1'b0;
        rxFlush    = 1'b0;
        if (wrSetup) begin
            if (wrData[ufdr_pkg::SET_EN]) begin
                next_setup = wrData[7:0];
                next_setup[ufdr_pkg::SET_TX_FL] = 1'b0;
                next_setup[ufdr_pkg::SET_RX_FL] = 1'b0;
                txFlush = wrData[ufdr_pkg::SET_TX_FL];
                rxFlush = wrData[ufdr_pkg::SET_RX_FL];
            end else begin
                next_setup[ufdr_pkg::SET_EN] = 1'b0;
            end
            // capacity changes, so stale contents go
            if (next_setup[ufdr_pkg::SET_EN] != fifoEnabled) begin
                txFlush = 1'b1;
                rxFlush = 1'b1;
            end
        end
        if (wrStrobe && wrAddr == ufdr_pkg::OFS_IRQ_EN) begin
            next_irqEn = wrData[1:0];
        end
    end

    // read mux
    always_comb begin
        rdValue = 32'h0000_0000;
        unique case (rdAddr)
            ufdr_pkg::OFS_SETUP:   rdValue[7:0] = setup;
            ufdr_pkg::OFS_IRQ_EN:  rdValue[1:0] = irqEn;
            ufdr_pkg::OFS_STATUS: begin
                rdValue[ufdr_pkg::ST_TX_CNT +: 6] = txCount;
                rdValue[ufdr_pkg::ST_RX_CNT +: 6] = rxCount;
                rdValue[ufdr_pkg::ST_TX_REQ] = txDmaRequestN;
                rdValue[ufdr_pkg::ST_RX_REQ] = rxDmaRequestN;
                rdValue[ufdr_pkg::ST_RX_IRQ] = rxCond;
                rdValue[ufdr_pkg::ST_TX_IRQ] = txCond;
                rdValue[ufdr_pkg::ST_EN]     = fifoEnabled;
            end
            ufdr_pkg::OFS_RX_DATA: begin
                if (!rxEmpty) begin
                    rdValue[7:0] = rxHead;
                end
            end
            default:               rdValue = 32'h0000_0000;
        endcase
    end

    // request and interrupt outputs
    always_comb begin
        if (blockMode) begin
            next_txReqN = txFull;
            if (rxDmaRequestN) begin
                next_rxReqN = !rxSet;
            end else begin
                next_rxReqN = rxEmpty;
            end
        end else begin
            next_txReqN = txCount != 6'h00;
            next_rxReqN = rxEmpty;
        end
        next_rxIrq = rxCond && irqEn[ufdr_pkg::IEN_RX];
        next_txIrq = txCond && irqEn[ufdr_pkg::IEN_TX];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setup         <= ufdr_pkg::SETUP_RST;
            irqEn         <= ufdr_pkg::IEN_RST;
            txDmaRequestN <= 1'b0;
            rxDmaRequestN <= 1'b1;
            rxReadyIrq    <= 1'b0;
            txEmptyIrq    <= 1'b0;
        end else if (ce) begin
            setup         <= next_setup;
            irqEn         <= next_irqEn;
            txDmaRequestN <= next_txReqN;
            rxDmaRequestN <= next_rxReqN;
            rxReadyIrq    <= next_rxIrq;
            txEmptyIrq    <= next_txIrq;
        end
    end

    a_tx_single_req: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && !blockMode |=> txDmaRequestN == ($past(txCount) != 6'h00))
        else $error("single mode tx request wrong");

    a_rx_single_req: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && !blockMode |=> rxDmaRequestN == ($past(rxCount) == 6'h00))
        else $error("single mode rx request wrong");

    a_tx_block_full: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && blockMode |=> txDmaRequestN == $past(txFull))
        else $error("block mode tx request not tied to full");

    a_rx_block_set: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && blockMode && rxCount >= rxLevel |=> !rxDmaRequestN)
        else $error("rx request not raised at threshold");

    a_rx_block_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && blockMode && !rxDmaRequestN && !rxEmpty |=> !rxDmaRequestN)
        else $error("rx request dropped before queue empty");

    a_rx_timeout_req: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && blockMode && rxTimeout && !rxEmpty |=> !rxDmaRequestN)
        else $error("time-out did not raise rx request");

    a_rx_irq_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce |=> rxReadyIrq == ($past(rxCond) && $past(irqEn[0])))
        else $error("rx interrupt not gated by enable");

    a_tx_irq_level: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && fifoEnabled && irqEn[1] && txCount < txLevel |=> txEmptyIrq)
        else $error("tx empty interrupt missing below threshold");

    a_tx_flush_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && wrSetup && wrData[0] && wrData[2]
        |=> txCount == 6'h00 && !setup[2])
        else $error("tx flush did not empty queue");

    a_rx_flush_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && wrSetup && wrData[0] && wrData[1]
        |=> rxCount == 6'h00 && !setup[1])
        else $error("rx flush did not empty queue");

    a_setup_guard: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && wrSetup && !wrData[0]
        |=> setup[7:1] == $past(setup[7:1]) && !setup[0])
        else $error("setup bits changed without enable bit");
endmodule

// [dv/ufdr_shifter_model.sv]
// behavioural model of the serial shifters on the queues' far side
`timescale 1ns/10ps
module ufdr_shifter_model (
    // clocking
    input  wire logic       clk,
    // receive shifter
    output logic            rxPush,
    output logic      [7:0] rxData,
    output logic            rxTimeout,
    // transmit shifter
    output logic            txPop
);
    initial begin
        rxPush    = 1'b0;
        rxData    = 8'h00;
        rxTimeout = 1'b0;
        txPop     = 1'b0;
    end

    // push held high across the burst, fresh byte each cycle
    task automatic pushBytes(input int n, output logic [7:0] last);
        for (int i = 0; i < n; i++) begin
            last = 8'($urandom);
            rxPush <= 1'b1;
            rxData <= last;
            @(posedge clk);
        end
        rxPush <= 1'b0;
        rxData <= ~last;
    endtask

    task automatic popBytes(input int n);
        txPop <= 1'b1;
        repeat (n) @(posedge clk);
        txPop <= 1'b0;
    endtask

    task automatic pulseTimeout;
        rxTimeout <= 1'b1;
        @(posedge clk);
        rxTimeout <= 1'b0;
    endtask
endmodule

// [dv/ufdr_top_test.sv]
// self-checking bench for the fifo setup and dma request block
`timescale 1ns/10ps
module ufdr_top_test;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ONE  = 32'h0000_0001;
    logic        clk;
    logic        sysRst;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        txPop;
    logic [7:0]  txData;
    logic        txEmpty;
    logic        rxPush;
    logic [7:0]  rxData;
    logic        rxTimeout;
    logic        rxFull;
    logic        txDmaRequestN;
    logic        rxDmaRequestN;
    logic        rxReadyIrq;
    logic        txEmptyIrq;
    logic        fifoEnabled;
    int          nErrors;
    int          compares;
    int          cycles;

    ufdr_top dut_u (
        .clk(clk), .ce(ce), .sys_rst(sysRst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txPop(txPop), .txData(txData), .txEmpty(txEmpty),
        .rxPush(rxPush), .rxData(rxData), .rxTimeout(rxTimeout),
        .rxFull(rxFull), .txDmaRequestN(txDmaRequestN),
        .rxDmaRequestN(rxDmaRequestN), .rxReadyIrq(rxReadyIrq),
        .txEmptyIrq(txEmptyIrq), .fifoEnabled(fifoEnabled)
    );

    ufdr_shifter_model m (
        .clk(clk), .rxPush(rxPush), .rxData(rxData),
        .rxTimeout(rxTimeout), .txPop(txPop)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [5:0] rxLvl(input logic [1:0] c);
        logic [5:0] t [4];
        t = '{6'h08, 6'h10, 6'h18, 6'h1C};
        return t[c];
    endfunction

    function automatic logic [5:0] txLvl(input logic [1:0] c);
        logic [5:0] t [4];
        t = '{6'h10, 6'h08, 6'h18, 6'h1E};
        return t[c];
    endfunction

    task automatic endOfTest;
        $display("errors %0d compares %0d", nErrors, compares);
        if (nErrors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // one single-word transfer, waits on ready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        q = hrdata;
        if (n >= 50) begin
            nErrors++;
            $display("[FAIL] %0t bus ready timeout", $time);
        end
        chk(32'(hresp), ZERO);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        ahb(1'b0, a, ZERO, q);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            nErrors++;
            endOfTest();
        end
    end

    initial begin
        logic [31:0] v;
        logic [31:0] s;
        logic [7:0]  b;
        logic [5:0]  lvl;
        nErrors = 0;
        compares = 0;
        cycles = 0;
        void'($urandom(32'h03bc_fe9b));
        sysRst = 1'b1;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = ZERO;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = ZERO;
        tick(3);
        sysRst <= 1'b0;
        tick(1);
        rd(ufdr_pkg::OFS_SETUP, v);
        chk(v, ZERO);
        chk(32'(fifoEnabled), ZERO);
        chk(32'(txDmaRequestN), ZERO);
        chk(32'(rxDmaRequestN), ONE);
        // legacy single-character path
        m.pushBytes(1, b);
        tick(3);
        chk(32'(rxDmaRequestN), ZERO);
        rd(ufdr_pkg::OFS_RX_DATA, v);
        chk(v, {24'h00_0000, b});
        tick(3);
        chk(32'(rxDmaRequestN), ONE);
        wr(ufdr_pkg::OFS_TX_DATA, $urandom);
        tick(3);
        chk(32'(txDmaRequestN), ONE);
        m.popBytes(1);
        tick(3);
        chk(32'(txDmaRequestN), ZERO);
        wr(ufdr_pkg::OFS_SETUP, 32'h0000_00F8);
        rd(ufdr_pkg::OFS_SETUP, v);
        chk(v, ZERO);
        // receive thresholds in block mode
        for (int c = 0; c < 4; c++) begin
            lvl = rxLvl(2'(c));
            s = {24'h00_0000, 2'(c), 6'h09};
            wr(ufdr_pkg::OFS_SETUP, s);
            rd(ufdr_pkg::OFS_SETUP, v);
            chk(v, s);
            m.pushBytes(int'(lvl) - 1, b);
            tick(3);
            chk(32'(rxDmaRequestN), ONE);
            m.pushBytes(1, b);
            tick(3);
            chk(32'(rxDmaRequestN), ZERO);
            rd(ufdr_pkg::OFS_STATUS, v);
            chk(32'(v[18]), ONE);
            chk(32'(rxReadyIrq), ZERO);
            wr(ufdr_pkg::OFS_IRQ_EN, ONE);
            tick(3);
            chk(32'(rxReadyIrq), ONE);
            if (c == 3) begin
                m.pushBytes(5, b);
                tick(3);
                chk(32'(rxFull), ONE);
                rd(ufdr_pkg::OFS_STATUS, v);
                chk(32'(v[13:8]), 32'h0000_0020);
                rd(ufdr_pkg::OFS_RX_DATA, v);
                rd(ufdr_pkg::OFS_RX_DATA, v);
                rd(ufdr_pkg::OFS_RX_DATA, v);
                rd(ufdr_pkg::OFS_RX_DATA, v);
            end
            rd(ufdr_pkg::OFS_RX_DATA, v);
            tick(3);
            chk(32'(rxReadyIrq), ZERO);
            chk(32'(rxDmaRequestN), ZERO);
            wr(ufdr_pkg::OFS_SETUP, s | 32'h0000_0002);
            tick(3);
            chk(32'(rxDmaRequestN), ONE);
            rd(ufdr_pkg::OFS_SETUP, v);
            chk(v, s);
            wr(ufdr_pkg::OFS_IRQ_EN, ZERO);
        end
        // transmit thresholds in block mode
        wr(ufdr_pkg::OFS_IRQ_EN, 32'h0000_0002);
        for (int c = 0; c < 4; c++) begin
            lvl = txLvl(2'(c));
            s = {24'h00_0000, 2'b00, 2'(c), 4'h9};
            wr(ufdr_pkg::OFS_SETUP, s);
            b = 8'($urandom);
            wr(ufdr_pkg::OFS_TX_DATA, {24'h00_0000, b});
            for (int i = 1; i < int'(lvl); i++)
                wr(ufdr_pkg::OFS_TX_DATA, $urandom);
            tick(3);
            chk(32'(txData), 32'(b));
            chk(32'(txEmptyIrq), ZERO);
            m.popBytes(1);
            tick(3);
            chk(32'(txEmptyIrq), ONE);
            for (int i = int'(lvl) - 1; i < 32; i++)
                wr(ufdr_pkg::OFS_TX_DATA, $urandom);
            tick(3);
            chk(32'(txDmaRequestN), ONE);
            m.popBytes(1);
            tick(3);
            chk(32'(txDmaRequestN), ZERO);
            wr(ufdr_pkg::OFS_SETUP, s | 32'h0000_0004);
            tick(3);
            chk(32'(txEmpty), ONE);
            rd(ufdr_pkg::OFS_SETUP, v);
            chk(v, s);
        end
        // time-out below threshold
        wr(ufdr_pkg::OFS_SETUP, 32'h0000_0009);
        m.pushBytes(2, b);
        tick(3);
        chk(32'(rxDmaRequestN), ONE);
        m.pulseTimeout();
        tick(3);
        chk(32'(rxDmaRequestN), ZERO);
        // clock enable low freezes the queues, pushes are lost
        ce <= 1'b0;
        m.pushBytes(3, b);
        chk(32'(hreadyout), ZERO);
        chk(32'(rxDmaRequestN), ZERO);
        ce <= 1'b1;
        tick(1);
        rd(ufdr_pkg::OFS_STATUS, v);
        chk(32'(v[13:8]), 32'h0000_0002);
        chk(32'(fifoEnabled), ONE);
        endOfTest();
    end
endmodule
